//--- inc/smec_pkg.sv
// What this block does
// - Machine check only when microcode consumes item or on a page table write error.
// - Discarded faulty prefetch becomes soft error interrupt.
// - Lost error with lost data posts hard interrupt.
// - Fetch errors report restartable flag as one.
// - Instruction cache parity checks on dispatch or operand.
// - Separate data parity flags per data bank.
// - Separate tag parity flags per tag bank.
// - Record quadword aligned failing virtual address.
// - Multiple bit fill ECC error flags fill error.
// - Capture fill address and syndrome on fill error.
// - Held fill report blocks capture, marks lost errors.
// - Lost fill error as cause raises soft interrupt.
// - Lost data RAM error raises soft or hard.
// - Only read fill errors and parity errors can arm machine check.
// - Page table write error traps at any time.
package smec_pkg;
  // Bus and capture widths.
  localparam int AW  = 5;
  localparam int DW  = 32;
  localparam int VAW = 32;
  localparam int PAW = 32;
  localparam int SYW = 8;
  // Register byte offsets.
  localparam logic [AW-1:0] OFS_STATUS = 5'h00;
  localparam logic [AW-1:0] OFS_MASK   = 5'h04;
  localparam logic [AW-1:0] OFS_VADDR  = 5'h08;
  localparam logic [AW-1:0] OFS_FADDR  = 5'h0c;
  localparam logic [AW-1:0] OFS_SYND   = 5'h10;
  localparam logic [AW-1:0] OFS_ICACHE_STATUS_REG   = 5'h14;
  // Status and mask bit positions.
  localparam int ST_DP0  = 0;
  localparam int ST_DP1  = 1;
  localparam int ST_TP0  = 2;
  localparam int ST_TP1  = 3;
  localparam int ST_FILL = 4;
  localparam int ST_LOST = 5;
  localparam int ST_SOFT = 6;
  localparam int ST_HARD = 7;
  localparam int ST_W    = 8;
  // Instruction cache status register bits.
  localparam int ICACHE_STATUS_REG_EN   = 0;
  localparam int ICACHE_STATUS_REG_LOCK = 1;
  localparam int ICACHE_STATUS_REG_W    = 2;
  // Reset values.
  localparam logic [ST_W-1:0]   MASK_RST = 8'h00;
  localparam logic [ICACHE_STATUS_REG_W-1:0] ICACHE_STATUS_REG_RST = 2'h0;
  // Low address bits cleared for quadword alignment.
  localparam logic [VAW-1:0] QW_MASK = 32'h0000_0007;
  // Code reported for a synchronous read machine check.
  localparam logic [7:0] SYNC_READ_MCHECK_CODE = 8'h01;
  // Pending machine check tracker states.
  typedef enum logic [0:0] {PEND_IDLE, PEND_ARMED} smec_pend_t;
endpackage : smec_pkg

//--- inc/smec_reg_if.sv
// Decoded register access between the bus slave and the core.
interface smec_reg_if;
  import smec_pkg::*;
  logic          wr;     // One-cycle write strobe.
  logic [AW-1:0] addr;   // Byte address of the access.
  logic [DW-1:0] wdata;  // Write data.
  logic [DW-1:0] rdata;  // Read data for addr.
  modport bus  (output wr, output addr, output wdata, input rdata);
  modport core (input wr, input addr, input wdata, output rdata);
endinterface : smec_reg_if

//--- rtl/smec_avmm_slave.sv
// Avalon-MM slave that answers every access after one wait cycle.
module smec_avmm_slave
  import smec_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          ce_i,
  // Avalon-MM slave port.
  input  wire logic [AW-1:0] avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [DW-1:0] avs_writedata_i,
  output logic      [DW-1:0] avs_readdata_o,
  output logic               avs_waitrequest_o,
  // Decoded access towards the core.
  smec_reg_if.bus            rif
);
  logic ack;       // High in the cycle the access completes.
  logic next_ack;  // Acknowledge for the next cycle.
  logic req;       // A read or write is requested.

  assign req               = avs_read_i | avs_write_i;
  assign next_ack          = req & ~ack;
  // A frozen clock enable keeps the master waiting, so no write is lost.
  assign avs_waitrequest_o = req & ~(ack & ce_i);
  // The write lands on the edge at which waitrequest is low.
  assign rif.wr    = avs_write_i & ack & ce_i;
  assign rif.addr  = avs_address_i;
  assign rif.wdata = avs_writedata_i;

  // Acknowledge follows the request by one cycle.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack <= 1'b0;
    end else if (ce_i) begin
      ack <= next_ack;
    end
  end

  // Read data is registered in the wait cycle.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= '0;
    end else if (ce_i && avs_read_i && !ack) begin
      avs_readdata_o <= rif.rdata;
    end
  end
endmodule // smec_avmm_slave

//--- rtl/smec_sticky.sv
// Sticky flag vector: a set in the clearing cycle wins.
module smec_sticky #(
  parameter int W = 8
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         ce_i,
  // Set and clear vectors.
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  // Held flags.
  output logic      [W-1:0] q_o
);
  logic [W-1:0] next_q;  // Flags after this cycle.

  // Clear first, then set, so no event is lost.
  assign next_q = (q_o & ~clr_i) | set_i;

  // The flags move only while the clock enable is high.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_o <= '0;
    end else if (ce_i) begin
      q_o <= next_q;
    end
  end
endmodule // smec_sticky

//--- rtl/smec_top.sv
// Synchronous read machine check error capture and reporting.
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
module smec_top
  import smec_pkg::*;
#(
  parameter int VW = smec_pkg::VAW,  // Virtual address width.
  parameter int PW = smec_pkg::PAW,  // Fill address width.
  parameter int SW = smec_pkg::SYW   // Syndrome width.
) (
  // Clock, reset and clock enable.
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  ce_i,
  // Avalon-MM register port.
  input  wire logic [smec_pkg::AW-1:0] avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [smec_pkg::DW-1:0] avs_writedata_i,
  output logic      [smec_pkg::DW-1:0] avs_readdata_o,
  output logic                       avs_waitrequest_o,
  // Instruction cache parity error report.
  input  wire logic                  ic_par_err_i,
  input  wire logic                  ic_par_tag_i,
  input  wire logic                  ic_par_bank_i,
  input  wire logic [VW-1:0]         ic_par_vaddr_i,
  // Cache fill report.
  input  wire logic                  fill_valid_i,
  input  wire logic                  fill_ecc_multi_i,
  input  wire logic                  fill_is_read_i,
  input  wire logic                  fill_data_lost_i,
  input  wire logic [PW-1:0]         fill_addr_i,
  input  wire logic [SW-1:0]         fill_synd_i,
  // Microcode events.
  input  wire logic                  uc_consume_i,
  input  wire logic                  uc_flush_i,
  input  wire logic                  pte_wr_err_i,
  // Machine check and interrupt outputs.
  output logic                       mcheck_o,
  output logic      [7:0]            mcheck_code_o,
  output logic                       restartable_flag_o,
  output logic                       icache_enable_o,
  output logic                       irq_o
);
  import smec_pkg::*;

  smec_reg_if rif ();

  // Register state.
  logic [ST_W-1:0]   status;       // Sticky event flags.
  logic [ST_W-1:0]   mask;         // Interrupt enables.
  logic [VW-1:0]     vaddr;        // Failing cache virtual address.
  logic [PW-1:0]     faddr;        // Failing fill address.
  logic [SW-1:0]     synd;         // Failing fill syndrome.
  logic              icache_en;    // Cache enable written by software.
  logic              lock;         // Capture lock of the cache status.
  smec_pend_t        pend;         // Pending machine check tracker.
  smec_pend_t        next_pend;    // Tracker next state.

  // Event decode.
  logic              ic_err;       // Accepted parity error.
  logic              fill_err;     // Uncorrectable fill error.
  logic              fill_cap;     // Fill error that is latched.
  logic              fill_lost;    // Fill error that is only counted lost.
  logic              arm;          // Prefetched item became faulty.
  logic              fire;         // Consumption of a faulty item.
  logic              flush_soft;   // Faulty item discarded unused.
  logic [ST_W-1:0]   st_set;       // Status set vector.
  logic [ST_W-1:0]   st_clr;       // Status clear vector.

  // Register access decode.
  logic              wr_status;    // Write to the status register.
  logic              wr_mask;      // Write to the mask register.
  logic              wr_icache_status_reg;      // Write to the cache status register.
  logic              lock_clr;     // Lock cleared by software.
  logic [VW-1:0]     va_qw;        // Quadword aligned address.

  // Bus slave with one wait cycle.
  smec_avmm_slave u_slave (
    .clk_i             (clk_i),
    .rst_b_i           (rst_b_i),
    .ce_i              (ce_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .rif               (rif.bus)
  );

  // Write decode.
  assign wr_status = rif.wr && (rif.addr == OFS_STATUS);
  assign wr_mask   = rif.wr && (rif.addr == OFS_MASK);
  assign wr_icache_status_reg   = rif.wr && (rif.addr == OFS_ICACHE_STATUS_REG);
  // Writing a one to the lock bit rearms address capture.
  assign lock_clr  = wr_icache_status_reg && rif.wdata[ICACHE_STATUS_REG_LOCK];
  assign st_clr    = wr_status ? rif.wdata[ST_W-1:0] : '0;

  // Read selection; unmapped offsets read as zero.
  assign rif.rdata =
    (rif.addr == OFS_STATUS) ? DW'(status) :
    (rif.addr == OFS_MASK)   ? DW'(mask) :
    (rif.addr == OFS_VADDR)  ? DW'(vaddr) :
    (rif.addr == OFS_FADDR)  ? DW'(faddr) :
    (rif.addr == OFS_SYND)   ? DW'(synd) :
    (rif.addr == OFS_ICACHE_STATUS_REG)   ? DW'({lock, icache_en}) : '0;

  // Error event decode.
  assign ic_err    = ce_i && ic_par_err_i;
  assign fill_err  = ce_i && fill_valid_i && fill_ecc_multi_i;
  // A held report blocks capture; the new error is only lost.
  assign fill_cap  = fill_err && !status[ST_FILL];
  assign fill_lost = fill_err && status[ST_FILL];
  assign va_qw     = ic_par_vaddr_i & ~VW'(QW_MASK);

  // Cache parity and read fill errors arm the pending check.
  assign arm = ic_err ||
               (fill_err && fill_is_read_i);
  // The check is raised only when microcode uses the item.
  assign fire       = ce_i && (pend == PEND_ARMED) && uc_consume_i;
  assign flush_soft = ce_i && (pend == PEND_ARMED) && !uc_consume_i &&
                      uc_flush_i;

  // Status set vector, one bit per event.
  assign st_set[ST_DP0]  = ic_err && !ic_par_tag_i && !ic_par_bank_i;
  assign st_set[ST_DP1]  = ic_err && !ic_par_tag_i && ic_par_bank_i;
  assign st_set[ST_TP0]  = ic_err && ic_par_tag_i && !ic_par_bank_i;
  assign st_set[ST_TP1]  = ic_err && ic_par_tag_i && ic_par_bank_i;
  assign st_set[ST_FILL] = fill_err;
  assign st_set[ST_LOST] = fill_lost;
  // A lost error without data loss is reported as soft.
  assign st_set[ST_SOFT] = flush_soft ||
                           (fill_lost && !fill_data_lost_i);
  // A lost error that lost data is reported as hard.
  assign st_set[ST_HARD] = fill_lost && fill_data_lost_i;

  // Sticky status flags; held until written with a one.
  smec_sticky #(
    .W (ST_W)
  ) u_status (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .ce_i    (ce_i),
    .set_i   (st_set),
    .clr_i   (st_clr),
    .q_o     (status)
  );

  // One level interrupt for any unmasked status flag.
  assign irq_o = |(status & mask);

  // Mask register.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask <= MASK_RST;
    end else if (ce_i && wr_mask) begin
      mask <= rif.wdata[ST_W-1:0];
    end
  end

  // Cache enable bit, driven out to the instruction cache.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      icache_en <= ICACHE_STATUS_REG_RST[ICACHE_STATUS_REG_EN];
    end else if (ce_i && wr_icache_status_reg) begin
      icache_en <= rif.wdata[ICACHE_STATUS_REG_EN];
    end
  end
  assign icache_enable_o = icache_en;

  // Lock sets on a parity error; a new error wins over a clear.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock <= ICACHE_STATUS_REG_RST[ICACHE_STATUS_REG_LOCK];
    end else if (ce_i) begin
      lock <= ic_err | (lock & ~lock_clr);
    end
  end

  // Failing virtual address, captured while unlocked.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vaddr <= '0;
    end else if (ic_err && !lock) begin
      vaddr <= va_qw;
    end
  end

  // Fill address and syndrome, captured while no report is held.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      faddr <= '0;
      synd  <= '0;
    end else if (fill_cap) begin
      faddr <= fill_addr_i;
      synd  <= fill_synd_i;
    end
  end

  // Pending tracker: armed by a faulty prefetch, left on use or flush.
  always_comb begin
    next_pend = pend;
    case (pend)
      PEND_IDLE: begin
        if (arm) begin
          next_pend = PEND_ARMED;
        end
      end
      PEND_ARMED: begin
        // A new fault in the same cycle keeps the tracker armed.
        if ((fire || flush_soft) && !arm) begin
          next_pend = PEND_IDLE;
        end
      end
      default: begin
        next_pend = PEND_IDLE;
      end
    endcase
  end

  // Tracker state register.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend <= PEND_IDLE;
    end else if (ce_i) begin
      pend <= next_pend;
    end
  end

  // Machine check pulse, code and restart flag.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mcheck_o           <= 1'b0;
      mcheck_code_o      <= '0;
      restartable_flag_o <= 1'b0;
    end else if (ce_i) begin
      // A page table write error traps at once, not restartable.
      mcheck_o <= fire || pte_wr_err_i;
      if (pte_wr_err_i) begin
        mcheck_code_o      <= SYNC_READ_MCHECK_CODE;
        restartable_flag_o <= 1'b0;
      end else if (fire) begin
        // Fetch errors stop before visible state changes.
        mcheck_code_o      <= SYNC_READ_MCHECK_CODE;
        restartable_flag_o <= 1'b1;
      end
    end
  end

  // Checks on the error capture and reporting behaviour.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_mchk_needs_use: assert property (
    ($past(ce_i) && mcheck_o) |->
      $past((pend == PEND_ARMED && uc_consume_i) || pte_wr_err_i))
    else $error("Machine check without consumption.");

  a_flush_to_soft: assert property (
    (ce_i && pend == PEND_ARMED && uc_flush_i && !uc_consume_i &&
     !pte_wr_err_i) |=>
      status[ST_SOFT] && !mcheck_o)
    else $error("Discarded fault did not become soft interrupt.");

  a_lost_data_hard: assert property (
    (fill_err && status[ST_FILL] && fill_data_lost_i) |=>
      status[ST_HARD] && status[ST_LOST] && (irq_o || !mask[ST_HARD]))
    else $error("Lost data did not post hard interrupt.");

  a_use_restart: assert property (
    (fire && !pte_wr_err_i) |=> mcheck_o && restartable_flag_o &&
      mcheck_code_o == SYNC_READ_MCHECK_CODE)
    else $error("Consumed fault not reported restartable.");

  a_icache_arms: assert property (
    ic_err |=> pend == PEND_ARMED)
    else $error("Parity error did not arm the check.");

  a_data_bank: assert property (
    (ic_err && !ic_par_tag_i) |=>
      ($past(ic_par_bank_i) ? status[ST_DP1] : status[ST_DP0]))
    else $error("Data bank parity flag wrong.");

  a_tag_bank: assert property (
    (ic_err && ic_par_tag_i) |=>
      ($past(ic_par_bank_i) ? status[ST_TP1] : status[ST_TP0]))
    else $error("Tag bank parity flag wrong.");

  a_vaddr_capture: assert property (
    (ic_err && !lock) |=>
      vaddr == ($past(ic_par_vaddr_i) & ~VW'(QW_MASK)) && lock)
    else $error("Failing address not captured aligned.");

  a_fill_flag: assert property (
    fill_err |=> status[ST_FILL])
    else $error("Uncorrectable fill not flagged.");

  a_fill_capture: assert property (
    fill_cap |=> faddr == $past(fill_addr_i) && synd == $past(fill_synd_i))
    else $error("Fill address or syndrome not captured.");

  a_fill_blocked: assert property (
    (ce_i && status[ST_FILL]) |=> $stable(faddr) && $stable(synd))
    else $error("Held fill report overwritten.");

  a_lost_soft: assert property (
    (fill_lost && !fill_data_lost_i) |=> status[ST_SOFT])
    else $error("Lost fill error without soft interrupt.");

  a_lost_some_int: assert property (
    fill_lost |=> status[ST_SOFT] || status[ST_HARD])
    else $error("Lost error raised no interrupt.");

  a_write_no_arm: assert property (
    (ce_i && pend == PEND_IDLE && !ic_err && !fill_is_read_i) |=>
      pend == PEND_IDLE)
    else $error("Write error armed a machine check.");

  a_pte_trap: assert property (
    (ce_i && pte_wr_err_i) |=> mcheck_o && !restartable_flag_o)
    else $error("Page table write error not trapped.");

  a_flags_hold: assert property (
    (ce_i && !wr_status) |=> (status & $past(status)) == $past(status))
    else $error("Flag dropped without a software clear.");

  c_mchk_fired: cover property (fire ##1 mcheck_o);
  c_flush_soft: cover property (flush_soft ##1 status[ST_SOFT]);
  c_lost_hard: cover property (fill_lost && fill_data_lost_i ##1 irq_o);
  c_clear_rearm: cover property (wr_status && status[ST_FILL] ##1 fill_cap);
endmodule // smec_top

//--- verification/smec_fill_model.sv
// Fill side model: presents one fill report per bench request.
module smec_fill_model
  import smec_pkg::*;
(
  // Clock and reset.
  input  wire logic           clk_i,
  input  wire logic           rst_b_i,
  // Request from the bench.
  input  wire logic           req_i,
  input  wire logic           ecc_i,
  input  wire logic           rd_i,
  input  wire logic           lost_i,
  input  wire logic [PAW-1:0] addr_i,
  input  wire logic [SYW-1:0] synd_i,
  // Fill report towards the block.
  output logic                fill_valid_o,
  output logic                fill_ecc_multi_o,
  output logic                fill_is_read_o,
  output logic                fill_data_lost_o,
  output logic      [PAW-1:0] fill_addr_o,
  output logic      [SYW-1:0] fill_synd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // The report stands one cycle; outside it every qualifier toggles.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fill_valid_o     <= 1'b0;
      fill_ecc_multi_o <= 1'b0;
      fill_is_read_o   <= 1'b0;
      fill_data_lost_o <= 1'b0;
      fill_addr_o      <= '0;
      fill_synd_o      <= '0;
    end else begin
      fill_valid_o <= req_i;
      if (req_i) begin
        fill_ecc_multi_o <= ecc_i;
        fill_is_read_o   <= rd_i;
        fill_data_lost_o <= lost_i;
        fill_addr_o      <= addr_i;
        fill_synd_o      <= synd_i;
      end else begin
        // Stale qualifiers must never be taken for a report.
        fill_ecc_multi_o <= ~fill_ecc_multi_o;
        fill_is_read_o   <= ~fill_is_read_o;
        fill_data_lost_o <= ~fill_data_lost_o;
        fill_addr_o      <= ~fill_addr_o;
        fill_synd_o      <= ~fill_synd_o;
      end
    end
  end
endmodule // smec_fill_model

//--- verification/sync_mcheck_error_capture_tb_top.sv
// Self-checking bench for the machine check error capture block.
module sync_mcheck_error_capture_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import smec_pkg::*;
  // Clock, reset and register bus.
  logic          clk_i     = 1'b0;
  logic          rst_b_i   = 1'b0;
  logic          ce        = 1'b1;
  logic [AW-1:0] adr       = '0;
  logic          rd        = 1'b0;
  logic          wr        = 1'b0;
  logic [DW-1:0] wd        = '0;
  logic [DW-1:0] rdat;
  logic          wreq;
  // Event inputs.
  logic          par_err   = 1'b0;
  logic          par_tag   = 1'b0;
  logic          par_bank  = 1'b0;
  logic [31:0]   par_vaddr = '0;
  logic          f_req     = 1'b0;
  logic          f_ecc     = 1'b0;
  logic          f_rd      = 1'b0;
  logic          f_lost    = 1'b0;
  logic [31:0]   f_addr    = '0;
  logic [7:0]    f_synd    = '0;
  logic          consume   = 1'b0;
  logic          flush     = 1'b0;
  logic          pte       = 1'b0;
  // Fill report and results.
  logic          fv, fe, fr, fl;
  logic [31:0]   fa;
  logic [7:0]    fs;
  logic          mchk, restart, ic_en, irq;
  logic [7:0]    code;
  // Bench state.
  int            n_errors        = 0;
  int            samples_checked = 0;
  int            cyc             = 0;
  logic [31:0]   lfsr            = 32'h0000_806c;
  logic [31:0]   q, v, a;

  // Device under test.
  smec_top i_smec_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .ic_par_err_i(par_err), .ic_par_tag_i(par_tag),
    .ic_par_bank_i(par_bank), .ic_par_vaddr_i(par_vaddr),
    .fill_valid_i(fv), .fill_ecc_multi_i(fe), .fill_is_read_i(fr),
    .fill_data_lost_i(fl), .fill_addr_i(fa), .fill_synd_i(fs),
    .uc_consume_i(consume), .uc_flush_i(flush), .pte_wr_err_i(pte),
    .mcheck_o(mchk), .mcheck_code_o(code), .restartable_flag_o(restart),
    .icache_enable_o(ic_en), .irq_o(irq));
  // Fill side partner.
  smec_fill_model i_smec_fill_model (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .req_i(f_req), .ecc_i(f_ecc), .rd_i(f_rd), .lost_i(f_lost),
    .addr_i(f_addr), .synd_i(f_synd), .fill_valid_o(fv),
    .fill_ecc_multi_o(fe), .fill_is_read_o(fr), .fill_data_lost_o(fl),
    .fill_addr_o(fa), .fill_synd_o(fs));

  // Clock toggles every 4 ns, a period of 8 ns.
  always #4 clk_i = ~clk_i;

  // Cuts a hang short.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  // Pseudo random source.
  function automatic logic [31:0] lfsr_next();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h0020_0007 : 32'h0);
    return lfsr;
  endfunction
  // Expected captured address: quadword aligned.
  function automatic logic [31:0] qalign(input logic [31:0] x);
    return x & ~QW_MASK;
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Compares one result.
  task automatic check(input string what, input logic [DW-1:0] exp,
                       input logic [DW-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  // One bus access, held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [AW-1:0] ad,
                     input logic [DW-1:0] d, output logic [DW-1:0] r);
    @(posedge clk_i);
    adr <= ad;
    wd  <= d;
    wr  <= w;
    rd  <= !w;
    @(posedge clk_i);
    while (wreq !== 1'b0) @(posedge clk_i);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wr_reg(input logic [AW-1:0] ad, input logic [DW-1:0] d);
    bus(1'b1, ad, d, q);
    #1;
  endtask
  task automatic rd_reg(input logic [AW-1:0] ad);
    bus(1'b0, ad, '0, q);
  endtask
  // Instruction cache parity event, one cycle.
  task automatic ev_par(input logic t, input logic b, input logic [31:0] x);
    @(posedge clk_i);
    par_err   <= 1'b1;
    par_tag   <= t;
    par_bank  <= b;
    par_vaddr <= x;
    @(posedge clk_i);
    par_err <= 1'b0;
  endtask
  // Fill report through the partner; lands two edges later.
  task automatic ev_fill(input logic e, input logic r, input logic l,
                         input logic [31:0] x, input logic [7:0] s);
    @(posedge clk_i);
    f_req  <= 1'b1;
    f_ecc  <= e;
    f_rd   <= r;
    f_lost <= l;
    f_addr <= x;
    f_synd <= s;
    @(posedge clk_i);
    f_req <= 1'b0;
    @(posedge clk_i);
  endtask
  // Microcode event: 0 consume, 1 flush, 2 page table write error.
  task automatic uc(input int k, input logic m, input logic r);
    @(posedge clk_i);
    consume <= (k == 0);
    flush   <= (k == 1);
    pte     <= (k == 2);
    @(posedge clk_i);
    consume <= 1'b0;
    flush   <= 1'b0;
    pte     <= 1'b0;
    #1;
    check("mcheck", {31'h0, m}, {31'h0, mchk});
    if (m) check("restartable", {31'h0, r}, {31'h0, restart});
    @(posedge clk_i);
    #1;
    check("mcheck_pulse", 32'h0, {31'h0, mchk});
  endtask

  // Main sequence.
  initial begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd_reg(OFS_STATUS);
    check("status_rst", 32'h0, q);
    rd_reg(OFS_MASK);
    check("mask_rst", {24'h0, MASK_RST}, q);
    rd_reg(OFS_ICACHE_STATUS_REG);
    check("icache_status_reg_rst", {30'h0, ICACHE_STATUS_REG_RST}, q);
    wr_reg(5'h18, 32'hffff_ffff);
    rd_reg(5'h18);
    check("unmapped", 32'h0, q);
    uc(0, 1'b0, 1'b0);
    wr_reg(OFS_MASK, 32'hff);
    rd_reg(OFS_MASK);
    check("mask_rw", 32'hff, q);
    // Every bank and store of the instruction cache.
    for (int i = 0; i < 4; i++) begin
      wr_reg(OFS_ICACHE_STATUS_REG, 32'h1);
      v = lfsr_next();
      ev_par(i[1], i[0], v);
      #1;
      check("irq", 32'h1, {31'h0, irq});
      rd_reg(OFS_STATUS);
      check("par_flag", 32'h1 << i, q & 32'hf);
      rd_reg(OFS_VADDR);
      check("vaddr", qalign(v), q);
      ev_par(i[1], i[0], ~v);
      rd_reg(OFS_VADDR);
      check("vaddr_held", qalign(v), q);
      uc(0, 1'b1, 1'b1);
      wr_reg(OFS_STATUS, 32'hff);
      wr_reg(OFS_ICACHE_STATUS_REG, 32'h2);
      check("icache_en", 32'h0, {31'h0, ic_en});
    end
    check("code", {24'h0, SYNC_READ_MCHECK_CODE}, {24'h0, code});
    // Prefetched faulty item discarded by a branch.
    ev_par(1'b0, 1'b0, lfsr_next());
    uc(1, 1'b0, 1'b0);
    rd_reg(OFS_STATUS);
    check("soft", 32'h1, {31'h0, q[ST_SOFT]});
    uc(0, 1'b0, 1'b0);
    // Random masks against held data bank 0 and soft flags.
    for (int i = 0; i < 6; i++) begin
      v = lfsr_next();
      wr_reg(OFS_MASK, v & 32'hff);
      check("irq_mask", {31'h0, |(v[7:0] & 8'h41)}, {31'h0, irq});
    end
    wr_reg(OFS_STATUS, 32'hff);
    check("irq_clear", 32'h0, {31'h0, irq});
    wr_reg(OFS_MASK, 32'hff);
    // Fill errors, first captured then lost.
    a = lfsr_next();
    ev_fill(1'b1, 1'b1, 1'b0, a, a[15:8]);
    rd_reg(OFS_STATUS);
    check("fill_flag", 32'h10, q & 32'hf0);
    rd_reg(OFS_FADDR);
    check("fill_addr", a, q);
    rd_reg(OFS_SYND);
    check("fill_synd", {24'h0, a[15:8]}, q);
    uc(0, 1'b1, 1'b1);
    ev_fill(1'b1, 1'b1, 1'b1, ~a, ~a[15:8]);
    rd_reg(OFS_STATUS);
    check("lost_hard", 32'hb0, q & 32'hb0);
    rd_reg(OFS_FADDR);
    check("fill_held", a, q);
    uc(0, 1'b1, 1'b1);
    ev_fill(1'b1, 1'b1, 1'b0, ~a, 8'h5a);
    rd_reg(OFS_STATUS);
    check("lost_soft", 32'h70, q & 32'h70);
    uc(0, 1'b1, 1'b1);
    wr_reg(OFS_STATUS, 32'h10);
    rd_reg(OFS_STATUS);
    check("lost_kept", 32'h20, q & 32'h30);
    // Capture re-armed; a write fill error never arms a check.
    v = lfsr_next();
    ev_fill(1'b1, 1'b0, 1'b0, v, v[7:0]);
    rd_reg(OFS_FADDR);
    check("fill_rearm", v, q);
    uc(0, 1'b0, 1'b0);
    wr_reg(OFS_STATUS, 32'hff);
    ev_fill(1'b0, 1'b1, 1'b0, ~v, 8'h00);
    rd_reg(OFS_STATUS);
    check("no_ecc", 32'h0, q & 32'h10);
    uc(0, 1'b0, 1'b0);
    // Clock enable low freezes capture and the pending check.
    ev_par(1'b0, 1'b1, v);
    ce <= 1'b0;
    ev_par(1'b1, 1'b1, ~v);
    uc(0, 1'b0, 1'b0);
    ce <= 1'b1;
    rd_reg(OFS_STATUS);
    check("ce_freeze", 32'h2, q & 32'hf);
    uc(0, 1'b1, 1'b1);
    uc(2, 1'b1, 1'b0);
    stop_test();
  end
endmodule // sync_mcheck_error_capture_tb_top
